// ==== core/dbs_bridge.sv ====
// Dynamic bus sizing master: read data FIFO and the bus cycle engine
// Behaviour
// - Both acknowledges negated: hold the cycle open, add wait states.
// - Narrow acknowledge alone ends the cycle as an 8-bit port.
// - Wide acknowledge alone ends the cycle as a 16-bit port.
// - Both acknowledges together end the cycle as a 16-bit port.
// - Long word takes two cycles on 16-bit port, four on 8-bit.
// - Move maximum data per cycle; assume 16-bit port at cycle start.
// - Operand bytes numbered from most significant, byte 0 first.
// - Size pins show bytes still remaining, not bytes moved.
// - Address gives word base plus byte offset; offset steers lanes.
// - No misaligned cycles; three-byte code only mid long-word on 8-bit.
// - Odd word or long request raises address error, runs no cycle.
// - Byte read at even address taken from lines 15..8.
// - Byte write drives the byte on both halves of data lines.
// - Odd byte on 16-bit port uses lines 7..0.
// - Word to 8-bit port: word code first, then byte at odd address.
// - At most one aligned word per cycle; high word before low word.
// - Size codes: 01 byte, 10 word, 11 three bytes, 00 long.
// - Read data latched at the final edge of the bus cycle.
`timescale 1ns/100ps

module dbs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    wr_ptr_d;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW-1:0]    rd_ptr_d;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_q != DEPTH[PW:0]);
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d  = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
    end
  end

  // Storage needs no reset
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end
endmodule

module dbs_bridge (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           req_valid_i,
  output logic                                req_ready_o,
  input  wire logic                           req_read_i,
  input  wire logic [1:0]                     req_size_i,
  input  wire logic [31:0]                    req_addr_i,
  input  wire logic [dbs_pkg::OPERAND_W-1:0]  req_wdata_i,
  output logic                                wr_done_o,
  output logic                                addr_error_o,
  output logic                                rd_valid_o,
  input  wire logic                           rd_ready_i,
  output logic      [dbs_pkg::OPERAND_W-1:0]  rd_data_o,
  output logic      [31:0]                    bus_addr_o,
  output logic                                transfer_size_code_high_o,
  output logic                                transfer_size_code_low_o,
  output logic                                bus_read_o,
  output logic                                bus_cycle_active_o,
  output logic      [dbs_pkg::DATA_LINES_W-1:0] data_lines_o,
  output logic                                data_lines_oe_n_o,
  input  wire logic [dbs_pkg::DATA_LINES_W-1:0] data_lines_i,
  input  wire logic                           wide_port_acknowledge_n_i,
  input  wire logic                           narrow_port_acknowledge_n_i
);
  import dbs_pkg::*;

  function automatic logic [2:0] op_bytes(input logic [1:0] size);
    case (size)
      SIZE_BYTE:  op_bytes = BYTES_ONE;
      SIZE_WORD:  op_bytes = BYTES_TWO;
      SIZE_THREE: op_bytes = BYTES_THREE;
      default:    op_bytes = BYTES_FOUR;
    endcase
  endfunction

  // Left-justify so that byte 0 sits in bits 31..24
  function automatic logic [31:0] left_just(input logic [31:0] d, input logic [1:0] size);
    case (size)
      SIZE_BYTE: left_just = {d[7:0], 24'h000000};
      SIZE_WORD: left_just = {d[15:0], 16'h0000};
      default:   left_just = d;
    endcase
  endfunction

  dbs_state_type    state_q;
  dbs_state_type    state_d;
  logic [1:0]       ack_s1_q;
  logic [1:0]       ack_s2_q;
  logic [15:0]      dat_s1_q;
  logic [15:0]      dat_s2_q;
  logic [31:0]      addr_q;
  logic [31:0]      addr_d;
  logic [2:0]       remain_q;
  logic [2:0]       remain_d;
  logic [31:0]      oper_q;
  logic [31:0]      oper_d;
  logic [31:0]      acc_q;
  logic [31:0]      acc_d;
  logic             rw_q;
  logic             rw_d;
  logic             wr_done_d;
  logic             aerr_d;
  logic [15:0]      dout_d;
  logic [2:0]       moved;
  logic [7:0]       rd_byte;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [31:0]      fifo_out_data;
  logic             fifo_pop;
  logic             rd_valid_d;
  logic [31:0]      rd_data_d;

  // Two-stage synchronisers for pins
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_s1_q <= ACK_WAIT;
      ack_s2_q <= ACK_WAIT;
      dat_s1_q <= LINES_RESET;
      dat_s2_q <= LINES_RESET;
    end
    else
    begin
      ack_s1_q <= {wide_port_acknowledge_n_i, narrow_port_acknowledge_n_i};
      ack_s2_q <= ack_s1_q;
      dat_s1_q <= data_lines_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  always_comb
  begin
    state_d   = state_q;
    addr_d    = addr_q;
    remain_d  = remain_q;
    oper_d    = oper_q;
    acc_d     = acc_q;
    rw_d      = rw_q;
    wr_done_d = 1'b0;
    aerr_d    = 1'b0;
    moved     = BYTES_NONE;
    rd_byte   = dat_s2_q[15:8];
    case (state_q)
      ST_IDLE:
      begin
        if (req_valid_i && req_ready_o)
        begin
          // Odd word or long, or a lone three-byte size, runs no cycle
          if ((req_size_i != SIZE_BYTE && req_addr_i[0]) || req_size_i == SIZE_THREE)
            aerr_d = 1'b1;
          else
          begin
            addr_d   = req_addr_i;
            remain_d = op_bytes(req_size_i);
            oper_d   = left_just(req_wdata_i, req_size_i);
            rw_d     = req_read_i;
            acc_d    = DATA_RESET;
            state_d  = ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        if (ack_s2_q != ACK_WAIT)
        begin
          // Narrow alone means 8-bit; wide alone or both means 16-bit
          if (ack_s2_q == ACK_NARROW || remain_q == BYTES_ONE || addr_q[0])
            moved = BYTES_ONE;
          else
            moved = BYTES_TWO;
          if (ack_s2_q != ACK_NARROW && addr_q[0])
            rd_byte = dat_s2_q[7:0];
          if (rw_q == RW_READ)
            acc_d = (moved == BYTES_TWO) ? {acc_q[15:0], dat_s2_q} : {acc_q[23:0], rd_byte};
          oper_d   = oper_q << {moved, 3'b000};
          addr_d   = addr_q + {29'h0, moved};
          remain_d = remain_q - moved;
          state_d  = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // Wait for the slave to release before the next cycle
        if (ack_s2_q == ACK_WAIT)
        begin
          if (remain_q != BYTES_NONE)
            state_d = ST_RUN;
          else if (rw_q == RW_READ)
            state_d = ST_PUSH;
          else
          begin
            wr_done_d = 1'b1;
            state_d   = ST_IDLE;
          end
        end
      end
      ST_PUSH:
      begin
        if (fifo_in_ready)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    // Byte writes go on both halves since the port width is unknown
    if (remain_d == BYTES_ONE)
      dout_d = {oper_d[31:24], oper_d[31:24]};
    else
      dout_d = oper_d[31:16];
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q                   <= ST_IDLE;
      addr_q                    <= ADDR_RESET;
      remain_q                  <= BYTES_NONE;
      oper_q                    <= DATA_RESET;
      acc_q                     <= DATA_RESET;
      rw_q                      <= RW_READ;
      req_ready_o               <= 1'b0;
      wr_done_o                 <= 1'b0;
      addr_error_o              <= 1'b0;
      bus_addr_o                <= ADDR_RESET;
      transfer_size_code_high_o <= 1'b0;
      transfer_size_code_low_o  <= 1'b0;
      bus_read_o                <= RW_READ;
      bus_cycle_active_o        <= 1'b0;
      data_lines_o              <= LINES_RESET;
      data_lines_oe_n_o         <= 1'b1;
    end
    else
    begin
      state_q                   <= state_d;
      addr_q                    <= addr_d;
      remain_q                  <= remain_d;
      oper_q                    <= oper_d;
      acc_q                     <= acc_d;
      rw_q                      <= rw_d;
      req_ready_o               <= (state_d == ST_IDLE) && !(req_valid_i && req_ready_o);
      wr_done_o                 <= wr_done_d;
      addr_error_o              <= aerr_d;
      bus_addr_o                <= addr_d;
      transfer_size_code_high_o <= remain_d[1];
      transfer_size_code_low_o  <= remain_d[0];
      bus_read_o                <= rw_d;
      bus_cycle_active_o        <= (state_d == ST_RUN);
      data_lines_o              <= (rw_d == RW_WRITE) ? dout_d : LINES_RESET;
      data_lines_oe_n_o         <= !((state_d == ST_RUN) && (rw_d == RW_WRITE));
    end
  end

  dbs_fifo #(
    .WIDTH(OPERAND_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (state_q == ST_PUSH),
    .in_ready_o (fifo_in_ready),
    .in_data_i  (acc_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o (fifo_out_data)
  );

  // Registered output stage behind the FIFO
  assign fifo_pop = !rd_valid_o || rd_ready_i;

  always_comb
  begin
    rd_valid_d = rd_valid_o;
    rd_data_d  = rd_data_o;
    if (fifo_pop)
    begin
      rd_valid_d = fifo_out_valid;
      rd_data_d  = fifo_out_data;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= DATA_RESET;
    end
    else
    begin
      rd_valid_o <= rd_valid_d;
      rd_data_o  <= rd_data_d;
    end
  end

  default clocking dbs_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_WAIT_STATE: assert property (
    (state_q == ST_RUN) && (ack_s2_q == ACK_WAIT) |=> (state_q == ST_RUN) && bus_cycle_active_o)
    else $error("Cycle did not stay open without acknowledge");
  AST_NARROW_STEP: assert property (
    (state_q == ST_RUN) && (ack_s2_q == ACK_NARROW) |=> addr_q == $past(addr_q) + 32'h1)
    else $error("Narrow acknowledge did not advance by one byte");
  AST_WIDE_STEP: assert property (
    (state_q == ST_RUN) && (ack_s2_q == ACK_BOTH) && (remain_q >= BYTES_TWO) && !addr_q[0]
      |=> addr_q == $past(addr_q) + 32'h2)
    else $error("Dual acknowledge not treated as 16-bit port");
  AST_NO_MISALIGN: assert property (
    bus_cycle_active_o && bus_addr_o[0] |-> transfer_size_code_low_o)
    else $error("Word or long cycle at odd address");
  AST_THREE_BYTE: assert property (
    bus_cycle_active_o && transfer_size_code_high_o && transfer_size_code_low_o |-> bus_addr_o[0])
    else $error("Three-byte cycle outside long-word sequence");
  AST_ADDR_ERROR: assert property (
    req_valid_i && req_ready_o && req_addr_i[0] && (req_size_i != SIZE_BYTE)
      |=> addr_error_o && !bus_cycle_active_o ##1 !bus_cycle_active_o)
    else $error("Misaligned request started a cycle");
  AST_BYTE_BOTH: assert property (
    bus_cycle_active_o && !bus_read_o && !transfer_size_code_high_o && transfer_size_code_low_o
      |-> data_lines_o[15:8] == data_lines_o[7:0] && !data_lines_oe_n_o)
    else $error("Byte write not on both halves");
  AST_READ_FLOAT: assert property (
    bus_read_o |-> data_lines_oe_n_o)
    else $error("Data lines driven in a read");
  AST_LONG_WIDE: assert property (
    (state_q == ST_RUN) && (ack_s2_q == ACK_WIDE) && (remain_q == BYTES_FOUR) && !addr_q[0]
      |=> (addr_q == $past(addr_q) + 32'h2) && transfer_size_code_high_o && !transfer_size_code_low_o)
    else $error("Second long-word cycle not a word");

  COV_LONG_NARROW: cover property (bus_cycle_active_o && transfer_size_code_high_o && transfer_size_code_low_o);
  COV_ODD_BYTE: cover property ((state_q == ST_RUN) && (ack_s2_q == ACK_WIDE) && addr_q[0]);
  COV_FIFO_FULL: cover property ((state_q == ST_PUSH) && !fifo_in_ready);
  COV_ADDR_ERR: cover property (addr_error_o);
endmodule

// ==== core/dbs_pkg.sv ====
// Constants shared by the dynamic bus sizing bridge
package dbs_pkg;
  // Transfer size codes on the size pins and on the core request
  localparam logic [1:0] SIZE_BYTE  = 2'b01;
  localparam logic [1:0] SIZE_WORD  = 2'b10;
  localparam logic [1:0] SIZE_THREE = 2'b11;
  localparam logic [1:0] SIZE_LONG  = 2'b00;
  // Synchronised acknowledge pair {wide_n, narrow_n}, active low pins
  localparam logic [1:0] ACK_WAIT   = 2'b11;
  localparam logic [1:0] ACK_NARROW = 2'b10;
  localparam logic [1:0] ACK_WIDE   = 2'b01;
  localparam logic [1:0] ACK_BOTH   = 2'b00;
  // Byte counts
  localparam logic [2:0] BYTES_ONE   = 3'h1;
  localparam logic [2:0] BYTES_TWO   = 3'h2;
  localparam logic [2:0] BYTES_THREE = 3'h3;
  localparam logic [2:0] BYTES_FOUR  = 3'h4;
  localparam logic [2:0] BYTES_NONE  = 3'h0;
  // Widths and reset values
  localparam int          DATA_LINES_W = 16;
  localparam int          OPERAND_W    = 32;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
  localparam logic [15:0] LINES_RESET  = 16'h0000;
  localparam logic        RW_READ      = 1'b1;
  localparam logic        RW_WRITE     = 1'b0;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP, ST_PUSH} dbs_state_type;
endpackage

// ==== tb/dbs_slave_model.sv ====
// Behavioural 8 or 16-bit slave on the far side of the sizing bridge
`timescale 1ns/100ps
module dbs_slave_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        port16_i,
  input  wire logic        both_i,
  input  wire logic [3:0]  waits_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic        read_i,
  input  wire logic        active_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             wide_n_o,
  output logic             narrow_n_o
);
  import dbs_pkg::*;
  logic [7:0] mem [16];
  logic [3:0] cnt_q;
  logic       ack_q;
  logic       w16;
  logic [3:0] a;
  assign w16 = port16_i | both_i;
  assign a   = addr_i[3:0];
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q      <= 4'h0;
      ack_q      <= 1'b0;
      wide_n_o   <= 1'b1;
      narrow_n_o <= 1'b1;
      rdata_o    <= 16'h0000;
    end
    else
    begin
      // Lines not driven by a valid answer keep changing
      rdata_o <= ~rdata_o;
      if (active_i && !ack_q && cnt_q != waits_i)
        cnt_q <= cnt_q + 4'h1;
      else if (active_i && !ack_q)
      begin
        ack_q      <= 1'b1;
        wide_n_o   <= ~w16;
        narrow_n_o <= w16 & ~both_i;
        if (read_i && w16)
          rdata_o <= {mem[{a[3:1], 1'b0}], mem[{a[3:1], 1'b1}]};
        else if (read_i)
          rdata_o <= {mem[a], ~rdata_o[7:0]};
        else if (!w16 || (size_i == SIZE_BYTE && !a[0]))
          mem[a] <= wdata_i[15:8];
        else if (size_i == SIZE_BYTE)
          mem[a] <= wdata_i[7:0];
        else
        begin
          mem[a]        <= wdata_i[15:8];
          mem[a + 4'h1] <= wdata_i[7:0];
        end
      end
      else if (ack_q && active_i)
        rdata_o <= rdata_o;
      else if (!active_i)
      begin
        ack_q      <= 1'b0;
        cnt_q      <= 4'h0;
        wide_n_o   <= 1'b1;
        narrow_n_o <= 1'b1;
      end
    end
  end
endmodule

// ==== tb/test_dynamic_bus_sizing.sv ====
// Self-checking bench for the dynamic bus sizing bridge
`timescale 1ns/100ps
module test_dynamic_bus_sizing;
  import dbs_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic        req_read_i = 1'b0;
  logic [1:0]  req_size_i = SIZE_BYTE;
  logic [31:0] req_addr_i = 32'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic        rd_ready_i = 1'b0;
  logic        p16 = 1'b0;
  logic        both = 1'b0;
  logic [3:0]  waits = 4'h0;
  logic        req_ready_o, wr_done_o, addr_error_o, rd_valid_o, sz_h, sz_l, bus_read_o, act, oe_n, wn, nn;
  logic [31:0] rd_data_o, bus_addr_o;
  logic [15:0] dout, din;
  logic [31:0] seq = 32'h1;
  logic [15:0] lastd;
  logic        lastoe;
  logic        lastrd;
  logic        inc = 1'b0;
  int          nact = 0;
  int          num_errors = 0;
  int          compares = 0;

  dbs_bridge u_dbs_bridge (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_read_i(req_read_i), .req_size_i(req_size_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .wr_done_o(wr_done_o), .addr_error_o(addr_error_o), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .bus_addr_o(bus_addr_o), .transfer_size_code_high_o(sz_h),
    .transfer_size_code_low_o(sz_l), .bus_read_o(bus_read_o), .bus_cycle_active_o(act), .data_lines_o(dout),
    .data_lines_oe_n_o(oe_n), .data_lines_i(din), .wide_port_acknowledge_n_i(wn),
    .narrow_port_acknowledge_n_i(nn));
  dbs_slave_model u_dbs_slave_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .port16_i(p16), .both_i(both),
    .waits_i(waits), .addr_i(bus_addr_o), .size_i({sz_h, sz_l}), .read_i(bus_read_o), .active_i(act),
    .wdata_i(dout), .rdata_o(din), .wide_n_o(wn), .narrow_n_o(nn));

  always #2 core_clk_i = ~core_clk_i;

  // Log size code and offset of each bus cycle
  always @(negedge core_clk_i)
  begin
    if (act === 1'b1 && !inc)
    begin
      seq = {seq[28:0], sz_h, sz_l, bus_addr_o[0]};
      lastd = dout;
      lastoe = oe_n;
      lastrd = bus_read_o;
    end
    if (act === 1'b1)
      nact++;
    inc = (act === 1'b1);
  end

  function automatic logic [31:0] mw(input int i);
    return {u_dbs_slave_model.mem[i], u_dbs_slave_model.mem[i+1], u_dbs_slave_model.mem[i+2],
      u_dbs_slave_model.mem[i+3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic issue(input logic r, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    seq = 32'h1;
    @(negedge core_clk_i);
    req_valid_i = 1'b1;
    req_read_i = r;
    req_size_i = s;
    req_addr_i = a;
    req_wdata_i = d;
    while (req_ready_o !== 1'b1 && n < 500)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk("req_ready", 1, req_ready_o);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
  endtask

  task automatic wait_end(input logic [1:0] e);
    int n;
    n = 0;
    while (!(wr_done_o | addr_error_o) && n < 2000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk("done_err", e, {wr_done_o, addr_error_o});
  endtask

  task automatic get_rd(input logic [31:0] e);
    int n;
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk("rd_valid", 1, rd_valid_o);
    chk("rd_data", e, rd_data_o);
    rd_ready_i = 1'b1;
    @(negedge core_clk_i);
    rd_ready_i = 1'b0;
  endtask

  task automatic wr(input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
    issue(1'b0, s, a, d);
    wait_end(2'b10);
  endtask

  task automatic rd(input logic [1:0] s, input logic [31:0] a, input logic [31:0] e);
    issue(1'b1, s, a, 32'h0);
    get_rd(e);
  endtask

  task automatic t_long8;
    p16 = 1'b0;
    waits = 4'h2;
    wr(SIZE_LONG, 32'h4, 32'h11223344);
    chk("seq", 32'b1_000_111_100_011, seq);
    chk("mem", 32'h11223344, mw(4));
    rd(SIZE_LONG, 32'h4, 32'h11223344);
    chk("seq", 32'b1_000_111_100_011, seq);
  endtask

  task automatic t_long16;
    p16 = 1'b1;
    waits = 4'h0;
    wr(SIZE_LONG, 32'h8, 32'haabbccdd);
    chk("seq", 32'b1_000_100, seq);
    chk("mem", 32'haabbccdd, mw(8));
    both = 1'b1;
    rd(SIZE_LONG, 32'h8, 32'haabbccdd);
    chk("seq", 32'b1_000_100, seq);
    both = 1'b0;
  endtask

  task automatic t_word8;
    p16 = 1'b0;
    wr(SIZE_WORD, 32'h2, 32'h5566);
    chk("seq", 32'b1_100_011, seq);
    chk("mem", 32'h5566, {16'h0, u_dbs_slave_model.mem[2], u_dbs_slave_model.mem[3]});
    rd(SIZE_WORD, 32'h2, 32'h5566);
  endtask

  task automatic t_byte;
    p16 = 1'b1;
    wr(SIZE_BYTE, 32'h1, 32'h77);
    chk("lines", 32'h7777, lastd);
    chk("oe_n", 0, lastoe);
    chk("seq", 32'b1_011, seq);
    chk("bus_read", 0, lastrd);
    rd(SIZE_BYTE, 32'h1, 32'h77);
    chk("bus_read", 1, lastrd);
    chk("oe_n", 1, lastoe);
    p16 = 1'b0;
    wr(SIZE_BYTE, 32'h0, 32'h99);
    chk("lines", 32'h9999, lastd);
    rd(SIZE_BYTE, 32'h0, 32'h99);
    p16 = 1'b1;
    rd(SIZE_BYTE, 32'h0, 32'h99);
  endtask

  task automatic t_err;
    issue(1'b0, SIZE_WORD, 32'h3, 32'h1);
    wait_end(2'b01);
    chk("seq", 1, seq);
    issue(1'b1, SIZE_LONG, 32'h5, 32'h0);
    wait_end(2'b01);
    chk("seq", 1, seq);
    issue(1'b0, SIZE_THREE, 32'h2, 32'h1);
    wait_end(2'b01);
    chk("seq", 1, seq);
  endtask

  task automatic t_wait;
    waits = 4'h9;
    nact = 0;
    wr(SIZE_WORD, 32'h6, 32'h1234);
    chk("held", 1, nact > 9);
    waits = 4'h0;
  endtask

  task automatic t_fifo;
    for (int i = 0; i < 10; i++)
      u_dbs_slave_model.mem[i] = 8'h30 + 8'(i);
    // Output register plus eight FIFO words, the tenth read must stall
    for (int i = 0; i < 10; i++)
      issue(1'b1, SIZE_BYTE, 32'(i), 32'h0);
    repeat (30) @(negedge core_clk_i);
    chk("full_ready", 0, req_ready_o);
    for (int i = 0; i < 10; i++)
      get_rd(32'h30 + 32'(i));
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    final_report;
  end

  initial
  begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    t_long8;
    t_long16;
    t_word8;
    t_byte;
    t_err;
    t_wait;
    t_fifo;
    final_report;
  end
endmodule
